//--- design/uhie_defines.vh
// Constants of the USB host interrupt event block: command codes, bit positions,
// masks and reset values.
// Assumes it is included by bare name from the design files of this block.
`ifndef UHIE_DEFINES_VH
`define UHIE_DEFINES_VH

// Command codes on the processor bus.
`define UHIE_CMD_RD_FLAGS 8'h03
`define UHIE_CMD_WR_FLAGS 8'h83
`define UHIE_CMD_RD_ENABLE 8'h04
`define UHIE_CMD_WR_ENABLE 8'h84
`define UHIE_CMD_WRITE_BIT 7

// Bit positions shared by the flag and enable registers; bit 31 is in the enable register only.
`define UHIE_BIT_SCHED_OVERRUN 0
`define UHIE_BIT_START_OF_FRAME 2
`define UHIE_BIT_RESUME_DETECT 3
`define UHIE_BIT_UNRECOV_ERROR 4
`define UHIE_BIT_FRAME_OVERFLOW 5
`define UHIE_BIT_ROOT_HUB_CHANGE 6
`define UHIE_BIT_MASTER_ENABLE 31

// Frame number counter width and its most significant bit.
`define UHIE_FRAME_WIDTH 16
`define UHIE_FRAME_MSB 15

// Implemented bits; every other position is reserved and reads zero.
`define UHIE_FLAGS_MASK 32'h0000007d
`define UHIE_ENABLE_MASK 32'h8000007d

// Reset values.
`define UHIE_FLAGS_RESET 32'h00000000
`define UHIE_ENABLE_RESET 32'h00000000
`define UHIE_OVERRUN_COUNT_RESET 2'h0

`endif

//--- design/uhie_change_watch.v
// Change watcher: flags any change of content across a set of equal words.
// Assumes the words come from logic on clk_sys; no synchronisers are needed.
`timescale 1ns/1ps

module uhie_change_watch #(
  parameter WORD_WIDTH = 32,
  parameter WORD_COUNT = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire clear,
  input wire [WORD_WIDTH*WORD_COUNT-1:0] words,
  output wire changed
);

  //////////////////////////////////////////////////////////////////////////////
  // The first sample after reset only primes the history, so a reset never looks like a change.
  reg primed;
  reg [WORD_WIDTH*WORD_COUNT-1:0] last_words;
  wire [WORD_COUNT-1:0] word_changed;

  always @(posedge clk_sys) begin
    if (!rst_n || clear) begin
      primed <= 1'b0;
      last_words <= {WORD_WIDTH*WORD_COUNT{1'b0}};
    end else begin
      primed <= 1'b1;
      last_words <= words;
    end
  end

  genvar w;
  generate
    for (w = 0; w < WORD_COUNT; w = w + 1) begin : g_word
      assign word_changed[w] = primed &&
        (words[w*WORD_WIDTH +: WORD_WIDTH] != last_words[w*WORD_WIDTH +: WORD_WIDTH]);
    end
  endgenerate

  assign changed = |word_changed;

endmodule // uhie_change_watch

//--- design/uhie_interrupt_events.v
// Interrupt event logic of a full-speed USB host controller: the event flag register,
// the set-on-write-one enable register with master enable, and the interrupt request.
// Functional notes
// - Set root hub change flag, bit 6, when hub or port status words change.
// - Set frame overflow flag, bit 5, whenever frame counter bit 15 toggles.
// - Set unrecoverable error flag, bit 4, on a system error unrelated to USB.
// - After that error halt lists and signalling; software clears flag after reset.
// - Set resume flag, bit 3, on new downstream resume, not software resume state.
// - At each frame start emit an SOF token and set flag bit 2.
// - On schedule overrun set flag bit 0 and increment the overrun counter.
// - Request interrupt only when flag, matching enable and master enable bit 31 set.
// - Each enable bit gates the flag at the same bit position.
// - Enable writes: ones set enable bits, zeros leave them unchanged.
// - Enable reads return present contents including master enable.
// - Enable register read with code 04h, written with code 84h.
// - Flag register read with code 03h, written with code 83h.
// - Software clears flags by writing ones only; hardware only sets flags.
// - Two-bit overrun counter starts at 00, wraps after 11, counts every overrun; code ignores overruns while processing_halt is set.
// Assumes every event input comes from controller logic clocked by clk_sys, and that
// the processor bus logic presents one command per cycle on cmd_valid.
`timescale 1ns/1ps
`include "uhie_defines.vh"

module uhie_interrupt_events #(
  parameter PORT_COUNT = 2,
  parameter STATUS_WIDTH = 32
) (
  input wire clk_sys,
  input wire rst_n,
  input wire soft_reset,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire [31:0] cmd_wdata,
  output reg rd_valid,
  output reg [31:0] rd_data,
  input wire [STATUS_WIDTH-1:0] root_hub_status_word,
  input wire [STATUS_WIDTH*PORT_COUNT-1:0] downstream_port_status_word,
  input wire [`UHIE_FRAME_WIDTH-1:0] frame_number_counter,
  input wire system_error,
  input wire downstream_resume,
  input wire software_resume_state,
  input wire frame_start,
  input wire schedule_overrun,
  output reg sof_token,
  output reg processing_halt,
  output reg [1:0] overrun_count,
  output reg interrupt_request
);

  //////////////////////////////////////////////////////////////////////////////
  // Registers and decode.

  reg [31:0] interrupt_event_flags;
  reg [31:0] interrupt_event_enable;
  reg last_frame_msb;
  reg last_resume;
  reg history_primed;

  reg [31:0] next_flags;
  reg [31:0] next_enable;
  reg [31:0] set_bits;
  reg [31:0] clear_bits;
  reg [1:0] next_overrun_count;
  reg next_halt;
  reg next_irq;

  wire root_hub_changed;
  wire master_interrupt_enable;

  wire wr_flags = cmd_valid && (cmd_code == `UHIE_CMD_WR_FLAGS);
  wire wr_enable = cmd_valid && (cmd_code == `UHIE_CMD_WR_ENABLE);
  wire rd_any = cmd_valid && !cmd_code[`UHIE_CMD_WRITE_BIT];

  // Either reset source brings flags, enables and counter back to zero.
  wire any_reset = !rst_n || soft_reset;

  assign master_interrupt_enable = interrupt_event_enable[`UHIE_BIT_MASTER_ENABLE];

  //////////////////////////////////////////////////////////////////////////////
  // Event detection.

  uhie_change_watch #(
    .WORD_WIDTH(STATUS_WIDTH),
    .WORD_COUNT(PORT_COUNT + 1)
  ) u_hub_watch (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clear(soft_reset),
    .words({downstream_port_status_word, root_hub_status_word}),
    .changed(root_hub_changed)
  );

  // Edge histories; the first cycle after reset only primes them.
  always @(posedge clk_sys) begin
    if (any_reset) begin
      last_frame_msb <= 1'b0;
      last_resume <= 1'b0;
      history_primed <= 1'b0;
    end else begin
      last_frame_msb <= frame_number_counter[`UHIE_FRAME_MSB];
      last_resume <= downstream_resume;
      history_primed <= 1'b1;
    end
  end

  always @* begin
    set_bits = 32'h00000000;
    set_bits[`UHIE_BIT_ROOT_HUB_CHANGE] = root_hub_changed;
    set_bits[`UHIE_BIT_FRAME_OVERFLOW] = history_primed &&
      (frame_number_counter[`UHIE_FRAME_MSB] != last_frame_msb);
    set_bits[`UHIE_BIT_UNRECOV_ERROR] = system_error;
    // A resume entered by software is not a device waking up, so it is not reported.
    set_bits[`UHIE_BIT_RESUME_DETECT] = history_primed && downstream_resume &&
      !last_resume && !software_resume_state;
    set_bits[`UHIE_BIT_START_OF_FRAME] = frame_start && !processing_halt;
    set_bits[`UHIE_BIT_SCHED_OVERRUN] = schedule_overrun && !processing_halt;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state of flags, enables, counter and halt.

  always @* begin
    clear_bits = wr_flags ? cmd_wdata : 32'h00000000;
    // Set wins over a clear in the same cycle, so no event is lost.
    next_flags = ((interrupt_event_flags & ~clear_bits) | set_bits) &
      `UHIE_FLAGS_MASK;
    next_enable = interrupt_event_enable;
    if (wr_enable) begin
      next_enable = (interrupt_event_enable | cmd_wdata) & `UHIE_ENABLE_MASK;
    end
    next_overrun_count = overrun_count;
    if (set_bits[`UHIE_BIT_SCHED_OVERRUN]) begin
      next_overrun_count = overrun_count + 2'h1;
    end
    // The halt holds until a reset; clearing the flag alone does not restart processing.
    next_halt = processing_halt || system_error;
    next_irq = next_enable[`UHIE_BIT_MASTER_ENABLE] &&
      (|(next_flags & next_enable & `UHIE_FLAGS_MASK));
  end

  //////////////////////////////////////////////////////////////////////////////
  // State registers and outputs.

  always @(posedge clk_sys) begin
    if (any_reset) begin
      interrupt_event_flags <= `UHIE_FLAGS_RESET;
      interrupt_event_enable <= `UHIE_ENABLE_RESET;
      overrun_count <= `UHIE_OVERRUN_COUNT_RESET;
      processing_halt <= 1'b0;
      interrupt_request <= 1'b0;
      sof_token <= 1'b0;
    end else begin
      interrupt_event_flags <= next_flags;
      interrupt_event_enable <= next_enable;
      overrun_count <= next_overrun_count;
      processing_halt <= next_halt;
      interrupt_request <= next_irq;
      sof_token <= frame_start && !processing_halt;
    end
  end

  // Read answers come one cycle after the command; unknown read codes answer zero.
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 32'h00000000;
    end else begin
      rd_valid <= rd_any;
      if (rd_any) begin
        case (cmd_code)
          `UHIE_CMD_RD_FLAGS: begin
            rd_data <= interrupt_event_flags & `UHIE_FLAGS_MASK;
          end
          `UHIE_CMD_RD_ENABLE: begin
            rd_data <= interrupt_event_enable & `UHIE_ENABLE_MASK;
          end
          default: begin
            rd_data <= 32'h00000000;
          end
        endcase
      end
    end
  end

endmodule // uhie_interrupt_events

//--- test/uhie_interrupt_events_monitor.sv
// Checker for the interrupt event block, bound to its top module.
// Assumes one clock, clk_sys, and synchronous resets.
`timescale 1ns/1ps
module uhie_interrupt_events_monitor (
  input wire clk_sys,
  input wire rst_n,
  input wire soft_reset,
  input wire cmd_valid,
  input wire [7:0] cmd_code,
  input wire rd_valid,
  input wire [31:0] rd_data,
  input wire system_error,
  input wire frame_start,
  input wire schedule_overrun,
  input wire sof_token,
  input wire processing_halt,
  input wire [1:0] overrun_count
);
  default clocking cb @(posedge clk_sys); endclocking
  // Software reset clears the same state as the pin except the read answer, and both mute the checks.
  default disable iff (!rst_n || soft_reset);
  AST_RD_ANSWER: assert property (rd_valid == $past(cmd_valid && !cmd_code[7]))
    else $error("read answer strobe wrong");
  AST_RSV_ZERO: assert property (rd_valid |-> (rd_data & 32'h7fffff82) == 32'h0)
    else $error("reserved bit read as one");
  AST_SOF: assert property (frame_start && !processing_halt |=> sof_token)
    else $error("frame start gave no token");
  AST_NO_SOF: assert property (!frame_start |=> !sof_token)
    else $error("token without frame start");
  AST_HALT: assert property (system_error |=> processing_halt)
    else $error("system error did not halt");
  AST_HALT_HOLD: assert property (processing_halt |=> processing_halt)
    else $error("halt lifted without reset");
  AST_OVR: assert property (schedule_overrun && !processing_halt
    |=> overrun_count == $past(overrun_count) + 2'h1)
    else $error("overrun count did not step");
  AST_OVR_HOLD: assert property (!schedule_overrun |=> $stable(overrun_count))
    else $error("overrun count moved alone");
  cover property (sof_token);
  cover property (processing_halt && frame_start);
  cover property (overrun_count == 2'h3 && schedule_overrun);
endmodule // uhie_interrupt_events_monitor

//--- test/uhie_host_model.sv
// Model of the host driver: one command at a time on the command bus.
// Assumes the bench calls its tasks; signals change at the falling edge.
`timescale 1ns/1ps
module uhie_host_model (
  input wire clk_sys,
  output reg cmd_valid = 1'b0,
  output reg [7:0] cmd_code = 8'h00,
  output reg [31:0] cmd_wdata = 32'h0,
  input wire rd_valid,
  input wire [31:0] rd_data
);
  // Released lines flip so a stale value is never mistaken for a live one.
  task wr(input [7:0] code, input [31:0] data);
    @(negedge clk_sys);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask
  task rd(input [7:0] code, output [31:0] data);
    wr(code, 32'h0);
    data = rd_valid ? rd_data : 32'hxxxxxxxx;
  endtask
endmodule // uhie_host_model

//--- test/uhie_interrupt_events_test.sv
// Self-checking bench for the interrupt event block.
// Assumes the host model and checker files are compiled first.
`timescale 1ns/1ps
module uhie_interrupt_events_test;
  reg clk_sys = 1'b0;
  reg rst_n = 1'b0;
  reg soft_reset = 1'b0;
  reg [31:0] hub = 32'h0;
  reg [63:0] ports = 64'h0;
  reg [15:0] frame = 16'h0;
  reg sys_err = 1'b0, resume = 1'b0, sw_resume = 1'b0, fstart = 1'b0, overrun = 1'b0;
  wire cmd_valid, rd_valid, sof_token, processing_halt, interrupt_request;
  wire [7:0] cmd_code;
  wire [31:0] cmd_wdata, rd_data;
  wire [1:0] overrun_count;
  integer miscompares = 0, checked = 0, i;
  reg [31:0] d;
  localparam [20:0] BITS = {3'd4, 3'd6, 3'd6, 3'd5, 3'd3, 3'd2, 3'd0};
  initial forever #2.5 clk_sys = ~clk_sys;
  uhie_host_model uhie_host_model_i (.clk_sys(clk_sys), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data));
  uhie_interrupt_events uhie_interrupt_events_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .soft_reset(soft_reset), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rd_valid(rd_valid), .rd_data(rd_data),
    .root_hub_status_word(hub), .downstream_port_status_word(ports),
    .frame_number_counter(frame), .system_error(sys_err), .downstream_resume(resume),
    .software_resume_state(sw_resume), .frame_start(fstart), .schedule_overrun(overrun),
    .sof_token(sof_token), .processing_halt(processing_halt),
    .overrun_count(overrun_count), .interrupt_request(interrupt_request));
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    checked = checked + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] code, input [31:0] data);
    uhie_host_model_i.wr(code, data);
  endtask
  task rd_chk(input [7:0] code, input [31:0] exp);
    uhie_host_model_i.rd(code, d);
    chk(d, exp);
  endtask
  task ev(input integer k);
    @(negedge clk_sys);
    case (k)
      0: overrun = 1'b1;
      1: fstart = 1'b1;
      2: resume = 1'b1;
      3: frame[15] = ~frame[15];
      4: ports[40] = ~ports[40];
      5: hub[3] = ~hub[3];
      default: sys_err = 1'b1;
    endcase
    @(negedge clk_sys);
    {overrun, fstart, resume, sys_err} = 4'h0;
  endtask
  task give_verdict;
    if (miscompares == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares = miscompares + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    rd_chk(8'h03, 32'h0);
    rd_chk(8'h04, 32'h0);
    wr(8'h84, 32'h00000004);
    wr(8'h84, 32'h80000000);
    rd_chk(8'h04, 32'h80000004);
    wr(8'h83, 32'hffffffff);
    rd_chk(8'h03, 32'h0);
    for (i = 0; i < 6; i = i + 1) begin
      ev(i);
      chk(interrupt_request, i == 1);
      chk(sof_token, i == 1);
      rd_chk(8'h03, 32'h1 << BITS[3*i +: 3]);
      wr(8'h83, 32'hffffffff);
      rd_chk(8'h03, 32'h0);
    end
    sw_resume = 1'b1;
    ev(2);
    rd_chk(8'h03, 32'h0);
    sw_resume = 1'b0;
    for (i = 0; i < 3; i = i + 1)
      ev(0);
    chk(overrun_count, 2'h0);
    wr(8'h84, 32'h0);
    rd_chk(8'h04, 32'h80000004);
    wr(8'h84, 32'hffffffff);
    rd_chk(8'h04, 32'h8000007d);
    chk(interrupt_request, 1'b1);
    ev(6);
    chk(processing_halt, 1'b1);
    rd_chk(8'h03, 32'h11);
    ev(1);
    chk(sof_token, 1'b0);
    wr(8'h83, 32'h10);
    rd_chk(8'h03, 32'h1);
    chk(processing_halt, 1'b1);
    @(negedge clk_sys);
    soft_reset = 1'b1;
    @(negedge clk_sys);
    soft_reset = 1'b0;
    chk(processing_halt, 1'b0);
    rd_chk(8'h03, 32'h0);
    rd_chk(8'h04, 32'h0);
    wr(8'h84, 32'h00000001);
    ev(0);
    chk(interrupt_request, 1'b0);
    chk(overrun_count, 2'h1);
    wr(8'h84, 32'h80000000);
    chk(interrupt_request, 1'b1);
    rd_chk(8'h04, 32'h80000001);
    give_verdict;
  end
endmodule // uhie_interrupt_events_test
bind uhie_interrupt_events uhie_interrupt_events_monitor uhie_interrupt_events_monitor_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .soft_reset(soft_reset), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .rd_valid(rd_valid), .rd_data(rd_data), .system_error(system_error),
  .frame_start(frame_start), .schedule_overrun(schedule_overrun), .sof_token(sof_token),
  .processing_halt(processing_halt), .overrun_count(overrun_count));
